// ---- core/scd_pkg.sv ----
// Purpose: Shared constants of the smart card clock divider and its host
// Assumes: Command byte is sent MSB first, B7..B5 chip address
// Notes:   Bit positions, reset values and cycle counts live here
package scd_pkg;
  // ----------------------------------------------------------------
  // Command byte layout
  // ----------------------------------------------------------------
  localparam int unsigned CMD_W       = 8;
  localparam int unsigned DIV_B0      = 0;
  localparam int unsigned DIV_B1      = 1;
  localparam int unsigned SLOPE_BIT   = 2;
  localparam int unsigned DATA_BIT    = 3;
  localparam int unsigned RST_BIT     = 4;
  localparam int unsigned ADDR_LSB    = 5;
  localparam int unsigned ADDR_W      = 3;
  localparam int unsigned BITCNT_W    = 4;

  // ----------------------------------------------------------------
  // Divide codes, written as {B0,B1}
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SCD_DIV_STOP = 2'b00,
    SCD_DIV_1    = 2'b01,
    SCD_DIV_2    = 2'b10,
    SCD_DIV_4    = 2'b11
  } scd_div_e;

  // ----------------------------------------------------------------
  // Status byte positions
  // ----------------------------------------------------------------
  localparam int unsigned ST_VCC_OV   = 0;
  localparam int unsigned ST_VCC_UV   = 1;
  localparam int unsigned ST_BAT_OV   = 2;
  localparam int unsigned ST_BAT_UV   = 3;
  localparam int unsigned ST_CARD     = 4;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [1:0]  DIV_RST     = 2'h0;
  localparam logic [1:0]  SUPPLY_RST  = 2'h0;
  localparam logic [7:0]  STATUS_RST  = 8'h00;
  localparam logic [1:0]  PHASE_RST   = 2'h0;
  localparam int unsigned CLK_MHZ     = 100;
  localparam int unsigned SETTLE_NS   = 200;
  localparam int unsigned SETTLE_CYC  = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SCLK_HALF   = 4;
  localparam int unsigned TIMER_W     = 8;
endpackage

// ---- core/scd_link_if.sv ----
// Purpose: Serial command link between host and card clock divider
// Assumes: One clock; both ends sample the link synchronously
// Notes:   Reply line has an enable; host masks the reply with it
`timescale 1ns/1ps
interface scd_link_if;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic miso;
  logic miso_oe;

  modport dev (
    input  cs_n,
    input  sclk,
    input  mosi,
    output miso,
    output miso_oe
  );

  modport host (
    output cs_n,
    output sclk,
    output mosi,
    input  miso,
    input  miso_oe
  );
endinterface

// ---- core/scd_device.sv ----
// Purpose: Card clock divider end of the smart card interface
// Assumes: Source clock and link inputs are synchronous to clk
// Notes:   Commands take effect only on chip select release
`timescale 1ns/1ps
module scd_device #(
  parameter logic [2:0] CHIP_ADDR   = 3'h1,
  parameter logic [2:0] SUPPLY_ADDR = 3'h5
) (
  input  wire logic    clk,
  input  wire logic    rst_n,
  scd_link_if.dev      link,
  input  wire logic    src_clk_in,
  input  wire logic    sync_mode_in,
  input  wire logic    card_detect_in,
  input  wire logic    vcc_over_in,
  input  wire logic    vcc_under_in,
  input  wire logic    bat_over_in,
  input  wire logic    bat_under_in,
  output logic         card_clock_out,
  output logic         card_reset_out,
  output logic         card_data_out,
  output logic         card_data_oe,
  output logic         slow_edge_select,
  output logic         fast_edge_select,
  output logic [1:0]   card_supply,
  output logic         supply_discharge_switch,
  output logic         int_n
);
  import scd_pkg::*;

  // ----------------------------------------------------------------
  // Link edge detection
  // ----------------------------------------------------------------
  logic                cs_n_q;
  logic                sclk_q;
  logic                src_q;
  logic                cs_fall;
  logic                cs_rise;
  logic                sclk_rise;
  logic                sclk_fall;
  logic                src_rise;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cs_n_q <= 1'b1;
      sclk_q <= 1'b0;
      src_q  <= 1'b0;
    end else begin
      cs_n_q <= link.cs_n;
      sclk_q <= link.sclk;
      src_q  <= src_clk_in;
    end
  end

  assign cs_fall   = cs_n_q & ~link.cs_n;
  assign cs_rise   = ~cs_n_q & link.cs_n;
  assign sclk_rise = ~link.cs_n & link.sclk & ~sclk_q;
  assign sclk_fall = ~link.cs_n & ~link.sclk & sclk_q;
  assign src_rise  = src_clk_in & ~src_q;

  // ----------------------------------------------------------------
  // Command shift register
  // ----------------------------------------------------------------
  logic [CMD_W-1:0]    shift_q;
  logic [BITCNT_W-1:0] bits_q;
  logic [2:0]          addr_now;
  logic                frame_ok;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shift_q <= '0;
      bits_q  <= '0;
    end else if (cs_fall) begin
      shift_q <= '0;
      bits_q  <= '0;
    end else if (sclk_rise) begin
      shift_q <= {shift_q[CMD_W-2:0], link.mosi};
      bits_q  <= (bits_q == BITCNT_W'(CMD_W)) ? BITCNT_W'(1) : bits_q + BITCNT_W'(1);
    end
  end

  // Extra bits beyond one byte start a new byte in the same frame
  assign addr_now = shift_q[ADDR_LSB +: ADDR_W];
  assign frame_ok = cs_rise & (bits_q == BITCNT_W'(CMD_W));

  // ----------------------------------------------------------------
  // Control latches
  // ----------------------------------------------------------------
  logic [1:0]          div_req_q;
  logic                slope_q;
  logic                data_q;
  logic                clk_write;
  logic                vcc_write;

  assign clk_write = frame_ok & (addr_now == CHIP_ADDR);
  assign vcc_write = frame_ok & (addr_now == SUPPLY_ADDR);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_req_q      <= DIV_RST;
      slope_q        <= 1'b0;
      data_q         <= 1'b0;
      card_reset_out <= 1'b0;
    end else if (clk_write) begin
      div_req_q      <= {shift_q[DIV_B0], shift_q[DIV_B1]};
      slope_q        <= shift_q[SLOPE_BIT];
      data_q         <= shift_q[DATA_BIT];
      card_reset_out <= shift_q[RST_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      card_supply <= SUPPLY_RST;
    end else if (vcc_write) begin
      card_supply <= {shift_q[DIV_B0], shift_q[DIV_B1]};
    end
  end

  // Edge rate may change on the fly, independent of ratio
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      slow_edge_select <= 1'b1;
      fast_edge_select <= 1'b0;
    end else begin
      slow_edge_select <= ~slope_q;
      fast_edge_select <= slope_q;
    end
  end

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  scd_div_e            div_act_q;
  logic [1:0]          phase_q;

  // Ratio swaps only at phase zero; a swap from SCD_DIV_1 to SCD_DIV_STOP still lets a one-cycle pulse reach the card
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phase_q   <= PHASE_RST;
      div_act_q <= SCD_DIV_STOP;
    end else if (src_rise) begin
      phase_q <= phase_q + 2'h1;
      if (phase_q == PHASE_RST) begin
        div_act_q <= scd_div_e'(div_req_q);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      card_clock_out <= 1'b0;
    end else if (sync_mode_in) begin
      card_clock_out <= data_q;
    end else begin
      unique case (div_act_q)
        SCD_DIV_STOP: card_clock_out <= 1'b0;
        SCD_DIV_1:    card_clock_out <= src_clk_in;
        SCD_DIV_2: begin
          if (src_rise) begin
            card_clock_out <= ~card_clock_out;
          end
        end
        SCD_DIV_4: begin
          if (src_rise && phase_q[0]) begin
            card_clock_out <= ~card_clock_out;
          end
        end
      endcase
    end
  end

  // Synchronous cards take data from the command bit instead
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      card_data_out <= 1'b0;
      card_data_oe  <= 1'b0;
    end else begin
      card_data_out <= data_q;
      card_data_oe  <= sync_mode_in;
    end
  end

  // ----------------------------------------------------------------
  // Faults and discharge
  // ----------------------------------------------------------------
  logic [7:0]          status_q;

  // Sticky faults; a new fault in the clear cycle is kept
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status_q <= STATUS_RST;
    end else begin
      status_q[ST_VCC_OV] <= vcc_over_in  | (status_q[ST_VCC_OV] & ~vcc_write);
      status_q[ST_VCC_UV] <= vcc_under_in | (status_q[ST_VCC_UV] & ~vcc_write);
      status_q[ST_BAT_OV] <= bat_over_in  | (status_q[ST_BAT_OV] & ~frame_ok);
      status_q[ST_BAT_UV] <= bat_under_in | (status_q[ST_BAT_UV] & ~frame_ok);
      status_q[ST_CARD]   <= card_detect_in;
      status_q[7:5]       <= 3'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      int_n                   <= 1'b1;
      supply_discharge_switch <= 1'b1;
    end else begin
      int_n                   <= ~(status_q[ST_VCC_OV] | status_q[ST_VCC_UV]);
      supply_discharge_switch <= (card_supply == SUPPLY_RST) | ~card_detect_in;
    end
  end

  // ----------------------------------------------------------------
  // Status read-out
  // ----------------------------------------------------------------
  logic [CMD_W-1:0]    tx_q;
  logic                miso_q;
  logic                miso_oe_q;

  // Reply drives only once the address bits name this chip
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_q      <= '0;
      miso_q    <= 1'b0;
      miso_oe_q <= 1'b0;
    end else if (cs_fall) begin
      tx_q      <= {status_q[CMD_W-2:0], 1'b0};
      miso_q    <= status_q[CMD_W-1];
      miso_oe_q <= 1'b0;
    end else if (link.cs_n) begin
      miso_oe_q <= 1'b0;
    end else begin
      if (sclk_fall) begin
        miso_q <= tx_q[CMD_W-1];
        tx_q   <= {tx_q[CMD_W-2:0], 1'b0};
      end
      if (sclk_rise && bits_q == BITCNT_W'(ADDR_W - 1)) begin
        miso_oe_q <= ({shift_q[1:0], link.mosi} == CHIP_ADDR);
      end
    end
  end

  assign link.miso    = miso_q;
  assign link.miso_oe = miso_oe_q;
endmodule

// ---- core/scd_host.sv ----
// Purpose: Host end issuing one command byte per request
// Assumes: Link clock is derived from clk by a divider
// Notes:   Busy covers the settle wait after each frame
`timescale 1ns/1ps
module scd_host #(
  parameter int unsigned HALF   = scd_pkg::SCLK_HALF,
  parameter int unsigned SETTLE = scd_pkg::SETTLE_CYC
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  scd_link_if.host               link,
  input  wire logic              req,
  input  wire logic [7:0]        cmd,
  output logic                   busy,
  output logic                   done,
  output logic [7:0]             rd_data
);
  import scd_pkg::*;

  typedef enum logic [2:0] {
    SCD_IDLE   = 3'b000,
    SCD_SEL    = 3'b001,
    SCD_LOW    = 3'b010,
    SCD_HIGH   = 3'b011,
    SCD_DESEL  = 3'b100,
    SCD_SETTLE = 3'b101
  } scd_hstate_e;

  scd_hstate_e           st_q;
  logic [TIMER_W-1:0]    tmr_q;
  logic [3:0]            nbit_q;
  logic [7:0]            tx_q;
  logic                  cs_n_q;
  logic                  sclk_q;
  logic                  mosi_q;

  // ----------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------
  // Caller supplies b4 at the wanted card reset level each time
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q    <= SCD_IDLE;
      tmr_q   <= '0;
      nbit_q  <= '0;
      tx_q    <= '0;
      cs_n_q  <= 1'b1;
      sclk_q  <= 1'b0;
      mosi_q  <= 1'b0;
      busy    <= 1'b0;
      done    <= 1'b0;
      rd_data <= '0;
    end else begin
      done <= 1'b0;
      if (tmr_q != '0) begin
        tmr_q <= tmr_q - TIMER_W'(1);
      end else begin
        unique case (st_q)
          SCD_IDLE: begin
            if (req) begin
              tx_q   <= cmd;
              busy   <= 1'b1;
              cs_n_q <= 1'b0;
              nbit_q <= '0;
              tmr_q  <= TIMER_W'(HALF - 1);
              st_q   <= SCD_SEL;
            end
          end
          SCD_SEL, SCD_LOW: begin
            sclk_q <= 1'b0;
            mosi_q <= tx_q[7];
            tmr_q  <= TIMER_W'(HALF - 1);
            st_q   <= SCD_HIGH;
          end
          SCD_HIGH: begin
            sclk_q  <= 1'b1;
            rd_data <= {rd_data[6:0], link.miso & link.miso_oe};
            tx_q    <= {tx_q[6:0], 1'b0};
            nbit_q  <= nbit_q + 4'h1;
            tmr_q   <= TIMER_W'(HALF - 1);
            st_q    <= (nbit_q == 4'h7) ? SCD_DESEL : SCD_LOW;
          end
          SCD_DESEL: begin
            sclk_q <= 1'b0;
            cs_n_q <= 1'b1;
            tmr_q  <= TIMER_W'(SETTLE - 1);
            st_q   <= SCD_SETTLE;
          end
          SCD_SETTLE: begin
            busy <= 1'b0;
            done <= 1'b1;
            st_q <= SCD_IDLE;
          end
          default: st_q <= SCD_IDLE;
        endcase
      end
    end
  end

  assign link.cs_n = cs_n_q;
  assign link.sclk = sclk_q;
  assign link.mosi = mosi_q;
endmodule

// ---- sim/scd_checker.sv ----
// Purpose: Concurrent checks on the command link and the card pins
// Assumes: One clock domain, synchronous active-low reset
// Notes:   Sees link signals and device pins as plain inputs
`timescale 1ns/1ps
module scd_checker (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       cs_n,
  input wire logic       sclk,
  input wire logic       mosi,
  input wire logic       miso_oe,
  input wire logic       card_clock_out,
  input wire logic       card_reset_out,
  input wire logic       slow_edge_select,
  input wire logic       fast_edge_select,
  input wire logic [1:0] card_supply,
  input wire logic       supply_discharge_switch,
  input wire logic       int_n,
  input wire logic       card_detect_in,
  input wire logic       vcc_over_in,
  input wire logic       vcc_under_in
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // Named steps
  // ----------------------------------------------------------------
  sequence s_supply_fault;
    vcc_over_in || vcc_under_in;
  endsequence
  sequence s_link_idle;
    cs_n && $past(cs_n);
  endsequence

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_edge_pick_excl: assert property (slow_edge_select != fast_edge_select)
    else $error("Edge selects not complementary");
  a_reset_clock_low: assert property (!$past(rst_n) |-> !card_clock_out && !card_reset_out)
    else $error("Card clock or reset high after reset");
  a_controls_hold: assert property (!($past(cs_n) && !$past(cs_n, 2)) |-> $stable(card_reset_out))
    else $error("Card reset moved outside latch slot");
  // Edge selects sit one flop behind the latched slope bit
  a_slope_hold: assert property (!($past(cs_n, 2) && !$past(cs_n, 3)) |-> $stable(slow_edge_select))
    else $error("Edge select moved outside latch slot");
  a_reply_off_idle: assert property (s_link_idle |-> !miso_oe)
    else $error("Reply driven without select");
  a_sclk_idle_low: assert property (s_link_idle |-> !sclk)
    else $error("Link clock active outside frame");
  a_mosi_steady: assert property (!cs_n && sclk && $past(sclk) |-> $stable(mosi))
    else $error("Command data moved while link clock high");
  a_fault_int_low: assert property (s_supply_fault |-> ##2 !int_n)
    else $error("Supply fault did not pull interrupt low");
  a_int_has_cause: assert property ($fell(int_n) |-> $past(vcc_over_in, 2) || $past(vcc_under_in, 2))
    else $error("Interrupt fell without supply fault");
  a_discharge_on: assert property ((card_supply == 2'h0 || !card_detect_in) |-> ##[0:2] supply_discharge_switch)
    else $error("Discharge off with zero supply or no card");
endmodule

// ---- sim/tb.sv ----
// Purpose: Host and divider ends joined, checked through host requests
// Assumes: Source clock 8 cycles a period, 50% duty
// Notes:   Short link half period and settle for a quick run
`timescale 1ns/1ps
module tb;
  import scd_pkg::*;
  logic       clk, rst_n, src_clk_in, sync_mode_in, card_detect_in;
  logic       vcc_over_in, vcc_under_in, bat_over_in, bat_under_in;
  logic       req, busy, done, oe_seen;
  logic [7:0] cmd, rd_data;
  logic       card_clock_out, card_reset_out, card_data_out, card_data_oe;
  logic       slow_edge_select, fast_edge_select, supply_discharge_switch, int_n;
  logic [1:0] card_supply;
  int         miscompares, checks, r, h;

  scd_link_if link ();
  scd_host #(.HALF(2), .SETTLE(2)) scd_host_i (.clk(clk), .rst_n(rst_n), .link(link), .req(req), .cmd(cmd),
    .busy(busy), .done(done), .rd_data(rd_data));
  scd_device scd_device_i (.clk(clk), .rst_n(rst_n), .link(link), .src_clk_in(src_clk_in),
    .sync_mode_in(sync_mode_in), .card_detect_in(card_detect_in), .vcc_over_in(vcc_over_in),
    .vcc_under_in(vcc_under_in), .bat_over_in(bat_over_in), .bat_under_in(bat_under_in),
    .card_clock_out(card_clock_out), .card_reset_out(card_reset_out), .card_data_out(card_data_out),
    .card_data_oe(card_data_oe), .slow_edge_select(slow_edge_select), .fast_edge_select(fast_edge_select),
    .card_supply(card_supply), .supply_discharge_switch(supply_discharge_switch), .int_n(int_n));
  scd_checker scd_checker_i (.clk(clk), .rst_n(rst_n), .cs_n(link.cs_n), .sclk(link.sclk), .mosi(link.mosi),
    .miso_oe(link.miso_oe), .card_clock_out(card_clock_out), .card_reset_out(card_reset_out),
    .slow_edge_select(slow_edge_select), .fast_edge_select(fast_edge_select), .card_supply(card_supply),
    .supply_discharge_switch(supply_discharge_switch), .int_n(int_n), .card_detect_in(card_detect_in),
    .vcc_over_in(vcc_over_in), .vcc_under_in(vcc_under_in));

  // ----------------------------------------------------------------
  // Clocks and helpers
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // 12.5 MHz source keeps every ratio under the card limit
  initial begin
    src_clk_in = 1'b0;
    forever begin
      repeat (4) @(negedge clk);
      src_clk_in = ~src_clk_in;
    end
  end
  always @(posedge clk) if (link.miso_oe === 1'b1) oe_seen <= 1'b1;

  function automatic logic [7:0] mk(input logic [2:0] a, input logic rs, d, f, input logic [1:0] c);
    return {a, rs, d, f, c[0], c[1]};
  endfunction

  task automatic report_and_stop();
    if (miscompares == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Request held until the host turns busy, so it is taken once
  task automatic send(input logic [7:0] c);
    int n;
    n = 0;
    @(negedge clk);
    cmd = c;
    req = 1'b1;
    while (done !== 1'b1 && n < 200) begin
      @(negedge clk);
      if (busy === 1'b1) req = 1'b0;
      n++;
    end
    if (n >= 200) begin
      miscompares++;
      report_and_stop();
    end
  endtask

  task automatic meas(output int rs, output int hs);
    logic p;
    p = card_clock_out;
    rs = 0;
    hs = 0;
    repeat (128) begin
      @(negedge clk);
      if (card_clock_out === 1'b1) hs++;
      if (card_clock_out === 1'b1 && p === 1'b0) rs++;
      p = card_clock_out;
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_n, req, sync_mode_in, vcc_over_in, vcc_under_in, bat_over_in, bat_under_in, oe_seen} = '0;
    cmd = 8'h00;
    card_detect_in = 1'b1;
    miscompares = 0;
    checks = 0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    chk("clock_after_reset", 8'h00, {7'h0, card_clock_out});
    chk("discharge_after_reset", 8'h01, {7'h0, supply_discharge_switch});
    for (int k = 0; k < 4; k++) begin
      send(mk(3'h1, k[0], 1'b0, k[1], k[1:0]));
      repeat (40) @(negedge clk);
      meas(r, h);
      chk("card_clock_rises", (k == 0) ? 8'h00 : 8'(32 >> k), 8'(r));
      chk("card_clock_high", (k == 0) ? 8'h00 : 8'h40, 8'(h));
      chk("card_reset", {7'h0, k[0]}, {7'h0, card_reset_out});
      chk("edge_select", {6'h0, k[1], ~k[1]}, {6'h0, fast_edge_select, slow_edge_select});
    end
    oe_seen = 1'b0;
    send(mk(3'h2, 1'b0, 1'b0, 1'b0, 2'b00));
    chk("foreign_ignored", 8'h03, {6'h0, card_reset_out, fast_edge_select});
    chk("foreign_reply", 8'h00, {7'h0, oe_seen});
    bat_over_in = 1'b1;
    @(negedge clk);
    bat_over_in = 1'b0;
    send(mk(3'h1, 1'b1, 1'b0, 1'b1, 2'b11));
    chk("status_battery", 8'h14, rd_data);
    chk("own_reply", 8'h01, {7'h0, oe_seen});
    send(mk(3'h1, 1'b1, 1'b0, 1'b1, 2'b11));
    chk("status_cleared", 8'h10, rd_data);
    vcc_under_in = 1'b1;
    repeat (3) @(negedge clk);
    vcc_under_in = 1'b0;
    chk("int_on_fault", 8'h00, {7'h0, int_n});
    send(mk(3'h1, 1'b1, 1'b0, 1'b1, 2'b11));
    chk("status_supply", 8'h12, rd_data);
    send(mk(3'h5, 1'b1, 1'b0, 1'b1, 2'b01));
    repeat (3) @(negedge clk);
    chk("int_cleared", 8'h01, {7'h0, int_n});
    chk("supply_level", 8'h01, {6'h0, card_supply});
    chk("discharge_off", 8'h00, {7'h0, supply_discharge_switch});
    card_detect_in = 1'b0;
    repeat (3) @(negedge clk);
    chk("discharge_removal", 8'h01, {7'h0, supply_discharge_switch});
    card_detect_in = 1'b1;
    sync_mode_in = 1'b1;
    for (int k = 1; k >= 0; k--) begin
      send(mk(3'h1, 1'b0, k[0], 1'b0, 2'b00));
      repeat (3) @(negedge clk);
      chk("sync_route", {5'h0, 1'b1, k[0], k[0]}, {5'h0, card_data_oe, card_clock_out, card_data_out});
    end
    report_and_stop();
  end
endmodule
